/* File: rtl/agum_top.sv */
`timescale 1ns/1ns
// Summary of operation
// - File direct reaches low 8192 bytes; move all
// - File ops use default register, result selectable
// - Post-modify: pointer is address, then stepped
// - Pre-modify: step pointer first, then address
// - Offset modes add register or literal
// - Three-operand general: first operand register direct
// - General class: direct, indirect, step modes, short literals
// - Move class adds offset modes, 8/16-bit literals
// - One offset register field serves both operands
// - Multiply pointers: two X reads, two Y
// - Multiply class: indirect, post by 2/4/6, indexed
// - Branch 16-bit signed, hold count 14-bit unsigned
// - One circular buffer each in X and Y
// - Power-of-two buffers check both bounds
// - Length from start/end difference, up to 32K words
// - Y circular addresses keep bit zero clear
// - X circular needs select not 15, enable set
// - Y circular needs select not 15, enable set
// - Bound checks detect beyond, not only equal
// - Only modify modes write corrected pointer back
module agum_top (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [agum_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    output logic [1:0]                       s_axi_bresp,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    input  wire logic [agum_pkg::AXI_AW-1:0] s_axi_araddr,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    input  wire logic                        reqValid,
    input  wire agum_pkg::agum_class_e       reqClass,
    input  wire agum_pkg::agum_mode_e        reqMode,
    input  wire agum_pkg::agum_unit_e        reqUnit,
    input  wire agum_pkg::agum_lit_e         reqLitKind,
    input  wire logic [3:0]                  reqPtrSel,
    input  wire logic [15:0]                 reqPtrVal,
    input  wire logic [3:0]                  reqOffSel,
    input  wire logic [15:0]                 reqOffVal,
    input  wire logic [15:0]                 reqLit,
    input  wire logic [2:0]                  reqStep,
    input  wire logic                        reqDestFile,
    output logic                             ansValid,
    output logic [15:0]                      ansEa,
    output logic                             ansMemAccess,
    output logic                             ansWbEn,
    output logic [15:0]                      ansWbVal,
    output logic [3:0]                       ansOffSel,
    output logic                             ansIllegal,
    output logic [15:0]                      ansLit,
    output logic                             ansDestFile,
    output logic [3:0]                       ansDestReg,
    output logic                             ansSpaceY,
    output logic                             ansCircular
);
    import agum_pkg::*;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] xs;
        logic [15:0] xe;
        logic [15:0] ys;
        logic [15:0] ye;
        logic [15:0] wraps;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        ansValid;
        logic [15:0] ansEa;
        logic        ansMem;
        logic        ansWbEn;
        logic [15:0] ansWb;
        logic [3:0]  ansOffSel;
        logic        ansIllegal;
        logic [15:0] ansLit;
        logic        ansDestFile;
        logic        ansSpaceY;
        logic        ansCirc;
    } agum_state_s;

    localparam agum_state_s RST_S = '{ctrl: CTRL_RST, xs: START_RST, xe: END_RST,
                                      ys: START_RST, ye: END_RST, default: '0};

    agum_state_s s_q;
    agum_state_s s_d;

    agum_circ_if cirX ();
    agum_circ_if cirY ();

    agum_circ uCircX (.cb(cirX));
    agum_circ uCircY (.cb(cirY));

    logic        wrTake;
    logic        rdTake;
    logic        isPost;
    logic        isPre;
    logic        isDec;
    logic        spaceY;
    logic        xOn;
    logic        yOn;
    logic        circOn;
    logic        bad;
    logic        memAcc;
    logic        wbEn;
    logic [15:0] delta;
    logic [15:0] offAdd;
    logic [15:0] rawEa;
    logic [15:0] rawWb;
    logic [15:0] corr;
    logic [15:0] finEa;
    logic [15:0] finWb;
    logic [15:0] litOut;

    function automatic logic [15:0] fMerge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0] = d[7:0];
        if (be[1]) r[15:8] = d[15:8];
        return r;
    endfunction

    // Write address and data are taken together; the response channel must be free
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !s_q.rvalid;
    assign wrTake        = s_axi_awready;
    assign rdTake        = s_axi_arvalid && s_axi_arready;

    assign isPost = reqMode inside {M_POSTINC, M_POSTDEC};
    assign isPre  = reqMode inside {M_PREINC, M_PREDEC};
    assign isDec  = reqMode inside {M_POSTDEC, M_PREDEC};
    assign delta  = isDec ? 16'h0000 - {13'h0000, reqStep} : {13'h0000, reqStep};
    assign offAdd = (reqMode == M_REGOFF) ? reqOffVal : reqLit;

    // Multiply pointers pick their unit from the register number; program space uses X
    assign spaceY = (reqClass == C_MAC) ? reqPtrSel inside {MAC_Y0, MAC_Y1}
                                        : reqUnit == U_Y;
    // A select of 15 never matches a usable pointer, so it turns the space off
    assign xOn = s_q.ctrl[XEN_BIT] && s_q.ctrl[XSEL_LSB+:4] != SEL_OFF
                 && s_q.ctrl[XSEL_LSB+:4] == reqPtrSel && !spaceY;
    assign yOn = s_q.ctrl[YEN_BIT] && s_q.ctrl[YSEL_LSB+:4] != SEL_OFF
                 && s_q.ctrl[YSEL_LSB+:4] == reqPtrSel && spaceY;
    assign circOn = (xOn || yOn) && memAcc;

    always_comb begin
        bad    = 1'b0;
        memAcc = 1'b1;
        wbEn   = 1'b0;
        rawEa  = reqPtrVal;
        rawWb  = reqPtrVal;
        unique case (reqClass)
            C_FILE: bad = reqMode != M_FILE;
            C_GEN: bad = !(reqMode inside {M_REGDIR, M_IND, M_POSTINC, M_POSTDEC, M_PREINC, M_PREDEC})
                         || !(reqLitKind inside {L_NONE, L_5, L_10, L_BRA, L_HOLD});
            C_MOVE: bad = !(reqLitKind inside {L_NONE, L_8, L_16});
            C_MAC: bad = !(reqPtrSel inside {MAC_X0, MAC_X1, MAC_Y0, MAC_Y1})
                         || !(reqMode inside {M_IND, M_POSTINC, M_POSTDEC, M_REGOFF})
                         || (isPost && !(reqStep inside {3'h2, 3'h4, 3'h6}))
                         || (reqMode == M_REGOFF && !(reqPtrSel inside {MAC_X1, MAC_Y1}))
                         || reqLitKind != L_NONE;
            default: bad = 1'b1;
        endcase
        unique case (reqMode)
            M_FILE: begin
                rawEa = (reqClass == C_MOVE) ? reqLit : {3'h0, reqLit[FILE_AW-1:0]};
            end
            M_REGDIR: memAcc = 1'b0;
            M_IND: rawEa = reqPtrVal;
            M_POSTINC, M_POSTDEC: begin
                rawEa = reqPtrVal;
                rawWb = reqPtrVal + delta;
                wbEn  = 1'b1;
            end
            M_PREINC, M_PREDEC: begin
                rawEa = reqPtrVal + delta;
                rawWb = rawEa;
                wbEn  = 1'b1;
            end
            M_REGOFF, M_LITOFF: rawEa = reqPtrVal + offAdd;
            default: bad = 1'b1;
        endcase
    end

    // Post modes correct the stepped pointer; the others correct the address itself
    assign cirX.en   = xOn && memAcc;
    assign cirX.lo   = s_q.xs;
    assign cirX.hi   = s_q.xe;
    assign cirX.addr = isPost ? rawWb : rawEa;
    assign cirX.up   = !isDec && !(reqMode inside {M_REGOFF, M_LITOFF} && offAdd[15]);
    assign cirX.down = isDec || (reqMode inside {M_REGOFF, M_LITOFF} && offAdd[15]);
    assign cirY.en   = yOn && memAcc;
    assign cirY.lo   = s_q.ys;
    assign cirY.hi   = s_q.ye;
    assign cirY.addr = cirX.addr;
    assign cirY.up   = cirX.up;
    assign cirY.down = cirX.down;

    // Only a live Y buffer forces word alignment; plain Y accesses keep bit zero
    assign corr  = spaceY ? ((yOn && memAcc) ? {cirY.out[15:1], 1'b0} : cirY.out) : cirX.out;
    assign finEa = isPost ? ((yOn && memAcc) ? {rawEa[15:1], 1'b0} : rawEa) : corr;
    assign finWb = (isPost || isPre) ? corr : rawWb;

    always_comb begin
        unique case (reqLitKind)
            L_5: litOut = {11'h000, reqLit[4:0]};
            L_10: litOut = {6'h00, reqLit[9:0]};
            L_8: litOut = {8'h00, reqLit[7:0]};
            L_16, L_BRA: litOut = reqLit;
            L_HOLD: litOut = {2'h0, reqLit[13:0]};
            default: litOut = 16'h0000;
        endcase
    end

    always_comb begin
        s_d = s_q;
        if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
        if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
        if (wrTake) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            unique case (s_axi_awaddr)
                CTRL_OFF: s_d.ctrl = fMerge(s_q.ctrl, s_axi_wdata, s_axi_wstrb);
                XSTART_OFF: s_d.xs = fMerge(s_q.xs, s_axi_wdata, s_axi_wstrb) & 16'hFFFE;
                XEND_OFF: s_d.xe = fMerge(s_q.xe, s_axi_wdata, s_axi_wstrb) | 16'h0001;
                YSTART_OFF: s_d.ys = fMerge(s_q.ys, s_axi_wdata, s_axi_wstrb) & 16'hFFFE;
                YEND_OFF: s_d.ye = fMerge(s_q.ye, s_axi_wdata, s_axi_wstrb) | 16'h0001;
                STATUS_OFF: s_d.bresp = RESP_OKAY;
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        if (rdTake) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                CTRL_OFF: s_d.rdata = {16'h0000, s_q.ctrl};
                XSTART_OFF: s_d.rdata = {16'h0000, s_q.xs};
                XEND_OFF: s_d.rdata = {16'h0000, s_q.xe};
                YSTART_OFF: s_d.rdata = {16'h0000, s_q.ys};
                YEND_OFF: s_d.rdata = {16'h0000, s_q.ye};
                STATUS_OFF: s_d.rdata = {s_q.wraps, s_q.ansEa};
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        s_d.ansValid = reqValid;
        if (reqValid) begin
            s_d.ansEa       = finEa;
            s_d.ansMem      = memAcc;
            s_d.ansWbEn     = wbEn && !bad;
            s_d.ansWb       = finWb;
            s_d.ansOffSel   = reqOffSel;
            s_d.ansIllegal  = bad;
            s_d.ansLit      = litOut;
            s_d.ansDestFile = reqDestFile;
            s_d.ansSpaceY   = spaceY;
            s_d.ansCirc     = circOn;
            if ((spaceY ? cirY.wrap : cirX.wrap) && !bad) s_d.wraps = s_q.wraps + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) s_q <= RST_S;
        else s_q <= s_d;
    end

    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp  = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata  = s_q.rdata;
    assign s_axi_rresp  = s_q.rresp;
    assign ansValid     = s_q.ansValid;
    assign ansEa        = s_q.ansEa;
    assign ansMemAccess = s_q.ansMem;
    assign ansWbEn      = s_q.ansWbEn;
    assign ansWbVal     = s_q.ansWb;
    assign ansOffSel    = s_q.ansOffSel;
    assign ansIllegal   = s_q.ansIllegal;
    assign ansLit       = s_q.ansLit;
    assign ansDestFile  = s_q.ansDestFile;
    assign ansDestReg   = DEFAULT_DEFAULT_WORKING_REGISTER;
    assign ansSpaceY    = s_q.ansSpaceY;
    assign ansCircular  = s_q.ansCirc;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence sWrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence sRdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence sPlainReq(agum_mode_e m);
        reqValid && reqMode == m && reqClass == C_GEN && reqPtrSel == SEL_OFF;
    endsequence

    AST_BRESP_NEXT: assert property (sWrTaken |=> s_axi_bvalid ##0 (s_axi_bvalid [*1]))
        else $error("write response missing");
    AST_FILE_NEAR: assert property (reqValid && reqMode == M_FILE && reqClass == C_FILE
        |=> ansValid && ansEa[15:13] == 3'h0) else $error("file address beyond near space");
    AST_POST_ADDR: assert property (sPlainReq(M_POSTINC)
        |=> ansEa == $past(reqPtrVal) && ansWbVal == 16'($past(reqPtrVal) + {13'h0000, $past(reqStep)}))
        else $error("post modify wrong");
    AST_PRE_ADDR: assert property (sPlainReq(M_PREDEC)
        |=> ansEa == 16'($past(reqPtrVal) - {13'h0000, $past(reqStep)}) && ansWbVal == ansEa)
        else $error("pre modify wrong");
    AST_OFF_NOWB: assert property (reqValid && reqMode inside {M_REGOFF, M_LITOFF}
        |=> !ansWbEn) else $error("offset mode wrote pointer");
    AST_MAC_PTR: assert property (reqValid && reqClass == C_MAC && !(reqPtrSel inside {[4'h8:4'hB]})
        |=> ansIllegal) else $error("multiply pointer accepted");
    AST_MAC_STEP: assert property (reqValid && reqClass == C_MAC && reqMode == M_POSTINC
        && !(reqStep inside {3'h2, 3'h4, 3'h6}) |=> ansIllegal) else $error("multiply step accepted");
    AST_HOLD_LIT: assert property (reqValid && reqLitKind == L_HOLD |=> ansLit[15:14] == 2'h0)
        else $error("hold count too wide");
    AST_Y_EVEN: assert property (ansValid && ansSpaceY && ansCircular |-> !ansEa[0])
        else $error("Y circular address odd");
    AST_X_OFF: assert property (reqValid && !spaceY && s_q.ctrl[XSEL_LSB+:4] == SEL_OFF
        |=> !ansCircular) else $error("X circular with select 15");
    AST_Y_EN: assert property (reqValid && spaceY && !s_q.ctrl[YEN_BIT]
        |=> !ansCircular) else $error("Y circular while disabled");
    AST_RD_NEXT: assert property (sRdTaken |=> s_axi_rvalid)
        else $error("read data missing");
    AST_ANS_PULSE: assert property (ansValid == $past(reqValid))
        else $error("answer strobe not one cycle after request");
endmodule

/* File: rtl/agum_pkg.sv */
package agum_pkg;
    localparam int unsigned AXI_AW = 8;
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] XSTART_OFF = 8'h04;
    localparam logic [7:0] XEND_OFF   = 8'h08;
    localparam logic [7:0] YSTART_OFF = 8'h0C;
    localparam logic [7:0] YEND_OFF   = 8'h10;
    localparam logic [7:0] STATUS_OFF = 8'h14;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] START_RST = 16'h0000;
    localparam logic [15:0] END_RST   = 16'h0001;
    localparam int unsigned XSEL_LSB = 0;
    localparam int unsigned YSEL_LSB = 4;
    localparam int unsigned YEN_BIT  = 14;
    localparam int unsigned XEN_BIT  = 15;
    localparam logic [3:0] SEL_OFF      = 4'hF;
    localparam logic [3:0] DEFAULT_DEFAULT_WORKING_REGISTER = 4'h0;
    localparam logic [3:0] MAC_X0       = 4'h8;
    localparam logic [3:0] MAC_X1       = 4'h9;
    localparam logic [3:0] MAC_Y0       = 4'hA;
    localparam logic [3:0] MAC_Y1       = 4'hB;
    localparam int unsigned FILE_AW = 13;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [8:0] {
        M_FILE    = 9'h001,
        M_REGDIR  = 9'h002,
        M_IND     = 9'h004,
        M_POSTINC = 9'h008,
        M_POSTDEC = 9'h010,
        M_PREINC  = 9'h020,
        M_PREDEC  = 9'h040,
        M_REGOFF  = 9'h080,
        M_LITOFF  = 9'h100
    } agum_mode_e;

    typedef enum logic [3:0] {
        C_FILE = 4'h1,
        C_GEN  = 4'h2,
        C_MOVE = 4'h4,
        C_MAC  = 4'h8
    } agum_class_e;

    typedef enum logic [3:0] {
        U_XRD  = 4'h1,
        U_XWR  = 4'h2,
        U_Y    = 4'h4,
        U_PROG = 4'h8
    } agum_unit_e;

    typedef enum logic [6:0] {
        L_NONE = 7'h01,
        L_5    = 7'h02,
        L_10   = 7'h04,
        L_8    = 7'h08,
        L_16   = 7'h10,
        L_BRA  = 7'h20,
        L_HOLD = 7'h40
    } agum_lit_e;
endpackage

/* File: rtl/agum_circ_if.sv */
`timescale 1ns/1ns
interface agum_circ_if;
    logic        en;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] addr;
    logic        up;
    logic        down;
    logic [15:0] out;
    logic        wrap;
    modport user (output en, lo, hi, addr, up, down, input out, wrap);
    modport corr (input en, lo, hi, addr, up, down, output out, wrap);
endinterface

/* File: rtl/agum_circ.sv */
`timescale 1ns/1ns
module agum_circ (
    agum_circ_if.corr cb
);
    import agum_pkg::*;

    logic [16:0] len;
    logic        lenOk;
    logic        bidir;
    logic        over;
    logic        under;

    // Length comes from the bounds alone; a reversed pair disables correction
    assign len   = {1'b0, cb.hi} - {1'b0, cb.lo} + 17'h00001;
    assign lenOk = cb.hi > cb.lo;
    assign bidir = (len & (len - 17'h00001)) == 17'h00000;
    // Strict compares so a step that jumps past a bound is still caught
    assign over  = cb.addr > cb.hi;
    assign under = cb.addr < cb.lo;

    always_comb begin
        cb.out  = cb.addr;
        cb.wrap = 1'b0;
        if (cb.en && lenOk && (cb.up || bidir) && over) begin
            cb.out  = cb.addr - len[15:0];
            cb.wrap = 1'b1;
        end else if (cb.en && lenOk && (cb.down || bidir) && under) begin
            cb.out  = cb.addr + len[15:0];
            cb.wrap = 1'b1;
        end
    end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
    import agum_pkg::*;
    logic        clk_sys = 1'h0;
    logic        rst_n = 1'h0;
    logic        awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
    logic [3:0]  wStrb = 4'hF;
    logic [31:0] wData = 32'h0, rData, capData;
    logic [1:0]  bResp, rResp, capResp;
    logic        reqValid = 1'h0, reqDestFile = 1'h0;
    agum_class_e reqClass = C_GEN;
    agum_mode_e  reqMode = M_IND;
    agum_unit_e  reqUnit = U_XRD;
    agum_lit_e   reqLitKind = L_NONE;
    logic [3:0]  reqPtrSel = 4'h0, reqOffSel = 4'h0, ansOffSel, ansDestReg;
    logic [15:0] reqPtrVal = 16'h0, reqOffVal = 16'h0, reqLit = 16'h0, ansEa, ansWbVal, ansLit;
    logic [2:0]  reqStep = 3'h0;
    logic        ansValid, ansMemAccess, ansWbEn, ansIllegal, ansDestFile, ansSpaceY, ansCircular;
    int          n_errors = 0, n_compared = 0;

    always #50 clk_sys = ~clk_sys;

    agum_top i_agum_top (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .reqValid(reqValid), .reqClass(reqClass), .reqMode(reqMode), .reqUnit(reqUnit),
        .reqLitKind(reqLitKind), .reqPtrSel(reqPtrSel), .reqPtrVal(reqPtrVal), .reqOffSel(reqOffSel),
        .reqOffVal(reqOffVal), .reqLit(reqLit), .reqStep(reqStep), .reqDestFile(reqDestFile),
        .ansValid(ansValid), .ansEa(ansEa), .ansMemAccess(ansMemAccess), .ansWbEn(ansWbEn),
        .ansWbVal(ansWbVal), .ansOffSel(ansOffSel), .ansIllegal(ansIllegal), .ansLit(ansLit),
        .ansDestFile(ansDestFile), .ansDestReg(ansDestReg), .ansSpaceY(ansSpaceY),
        .ansCircular(ansCircular)
    );

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready and valid only change at rising edges, so the level seen at the falling edge holds at the next rise
    task automatic waitSig(input int k);
        logic hit;
        hit = 1'h0;
        for (int i = 0; i < 20 && !hit; i++) begin
            @(negedge clk_sys);
            hit = (k == 0) ? (awReady === 1'h1 && wReady === 1'h1) : (k == 1) ? (bValid === 1'h1)
                : (k == 2) ? (arReady === 1'h1) : (rValid === 1'h1);
            capData = rData;
            capResp = (k == 1) ? bResp : rResp;
            @(posedge clk_sys);
        end
        if (!hit) begin
            n_errors++;
            $display("unexpected at %0t: handshake %0d timeout, got %h expected %h", $time, k, 1'h0, 1'h1);
            end_sim();
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awAddr <= a;
        wData <= d;
        awValid <= 1'h1;
        wValid <= 1'h1;
        bReady <= 1'h1;
        waitSig(0);
        awValid <= 1'h0;
        wValid <= 1'h0;
        waitSig(1);
        bReady <= 1'h0;
        chk(capResp, er);
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        arAddr <= a;
        arValid <= 1'h1;
        rReady <= 1'h1;
        waitSig(2);
        arValid <= 1'h0;
        waitSig(3);
        rReady <= 1'h0;
        chk(capData, ed);
        chk(capResp, er);
    endtask

    task automatic rq(input agum_class_e c, input agum_mode_e m, input agum_unit_e u, input agum_lit_e l,
                      input logic [3:0] s, input logic [15:0] p, input logic [15:0] o, input logic [15:0] lt,
                      input logic [2:0] st, input logic df);
        reqValid <= 1'h1;
        reqClass <= c;
        reqMode <= m;
        reqUnit <= u;
        reqLitKind <= l;
        reqPtrSel <= s;
        reqPtrVal <= p;
        reqOffSel <= 4'h5;
        reqOffVal <= o;
        reqLit <= lt;
        reqStep <= st;
        reqDestFile <= df;
        @(posedge clk_sys);
        reqValid <= 1'h0;
        @(negedge clk_sys);
        chk(ansValid, 1'h1);
        @(posedge clk_sys);
    endtask

    task automatic chkA(input logic [15:0] ea, input logic we, input logic [15:0] wb, input logic circ);
        chk({ansEa, ansWbVal}, {ea, wb});
        chk({ansWbEn, ansCircular, ansIllegal}, {we, circ, 1'h0});
    endtask

    task automatic t_regs();
        axr(CTRL_OFF, 32'h0, RESP_OKAY);
        axr(XEND_OFF, 32'h1, RESP_OKAY);
        axr(YSTART_OFF, 32'h0, RESP_OKAY);
        axw(8'h18, 32'h1, RESP_SLVERR);
        axr(8'h18, 32'h0, RESP_SLVERR);
        axw(STATUS_OFF, 32'h5, RESP_OKAY);
        axw(XSTART_OFF, 32'h0101, RESP_OKAY);
        axr(XSTART_OFF, 32'h0100, RESP_OKAY);
        axw(XEND_OFF, 32'h010E, RESP_OKAY);
        axr(XEND_OFF, 32'h010F, RESP_OKAY);
        axw(CTRL_OFF, 32'hFFFF_80F2, RESP_OKAY);
        axr(CTRL_OFF, 32'h80F2, RESP_OKAY);
        $display("registers test done");
    endtask

    task automatic t_xwrap();
        rq(C_GEN, M_POSTINC, U_XRD, L_NONE, 4'h2, 16'h010E, 16'h0, 16'h0, 3'h2, 1'h0);
        chkA(16'h010E, 1'h1, 16'h0100, 1'h1);
        rq(C_GEN, M_POSTINC, U_PROG, L_NONE, 4'h2, 16'h010C, 16'h0, 16'h0, 3'h6, 1'h0);
        chkA(16'h010C, 1'h1, 16'h0102, 1'h1);
        rq(C_GEN, M_PREDEC, U_XWR, L_NONE, 4'h2, 16'h0100, 16'h0, 16'h0, 3'h2, 1'h0);
        chkA(16'h010E, 1'h1, 16'h010E, 1'h1);
        rq(C_MOVE, M_REGOFF, U_XRD, L_NONE, 4'h2, 16'h010C, 16'h0006, 16'h0, 3'h0, 1'h0);
        chk({ansEa, ansWbEn, ansOffSel}, {16'h0102, 1'h0, 4'h5});
        rq(C_MOVE, M_LITOFF, U_XRD, L_NONE, 4'h2, 16'h010C, 16'h0, 16'h0004, 3'h0, 1'h0);
        chk({ansEa, ansWbEn}, {16'h0100, 1'h0});
        $display("x circular test done");
    endtask

    task automatic t_xoff();
        axw(CTRL_OFF, 32'h80FF, RESP_OKAY);
        rq(C_GEN, M_POSTINC, U_XRD, L_NONE, 4'hF, 16'h010E, 16'h0, 16'h0, 3'h2, 1'h0);
        chkA(16'h010E, 1'h1, 16'h0110, 1'h0);
        axw(CTRL_OFF, 32'h00F2, RESP_OKAY);
        rq(C_GEN, M_POSTINC, U_XRD, L_NONE, 4'h2, 16'h010E, 16'h0, 16'h0, 3'h2, 1'h0);
        chkA(16'h010E, 1'h1, 16'h0110, 1'h0);
        rq(C_GEN, M_PREDEC, U_XWR, L_NONE, 4'hF, 16'h0100, 16'h0, 16'h0, 3'h2, 1'h0);
        chkA(16'h00FE, 1'h1, 16'h00FE, 1'h0);
        $display("x disable test done");
    endtask

    task automatic t_y();
        axw(YSTART_OFF, 32'h0200, RESP_OKAY);
        axw(YEND_OFF, 32'h0206, RESP_OKAY);
        axw(CTRL_OFF, 32'h003F, RESP_OKAY);
        rq(C_GEN, M_PREINC, U_Y, L_NONE, 4'h3, 16'h0205, 16'h0, 16'h0, 3'h2, 1'h0);
        chk({ansEa, ansSpaceY, ansCircular}, {16'h0207, 1'h1, 1'h0});
        axw(CTRL_OFF, 32'h403F, RESP_OKAY);
        rq(C_GEN, M_PREINC, U_Y, L_NONE, 4'h3, 16'h0206, 16'h0, 16'h0, 3'h2, 1'h0);
        chk({ansEa, ansSpaceY, ansCircular}, {16'h0200, 1'h1, 1'h1});
        rq(C_GEN, M_PREINC, U_Y, L_NONE, 4'h3, 16'h0201, 16'h0, 16'h0, 3'h2, 1'h0);
        chk(ansEa, 16'h0202);
        rq(C_GEN, M_POSTINC, U_XRD, L_NONE, 4'h3, 16'h0206, 16'h0, 16'h0, 3'h2, 1'h0);
        chkA(16'h0206, 1'h1, 16'h0208, 1'h0);
        $display("y circular test done");
    endtask

    task automatic t_mac();
        rq(C_MAC, M_POSTINC, U_Y, L_NONE, 4'h9, 16'h0010, 16'h0, 16'h0, 3'h4, 1'h0);
        chk({ansWbVal, ansWbEn, ansIllegal, ansSpaceY}, {16'h0014, 3'h4});
        rq(C_MAC, M_IND, U_XRD, L_NONE, 4'hA, 16'h0010, 16'h0, 16'h0, 3'h0, 1'h0);
        chk({ansIllegal, ansSpaceY}, 2'h1);
        rq(C_MAC, M_POSTINC, U_XRD, L_NONE, 4'h8, 16'h0010, 16'h0, 16'h0, 3'h3, 1'h0);
        chk({ansIllegal, ansWbEn}, 2'h2);
        rq(C_MAC, M_IND, U_XRD, L_NONE, 4'h4, 16'h0010, 16'h0, 16'h0, 3'h0, 1'h0);
        chk(ansIllegal, 1'h1);
        rq(C_MAC, M_REGOFF, U_XRD, L_NONE, 4'h8, 16'h0010, 16'h0, 16'h0, 3'h0, 1'h0);
        chk(ansIllegal, 1'h1);
        $display("mac test done");
    endtask

    task automatic t_lit();
        agum_class_e lc[8] = '{C_GEN, C_GEN, C_GEN, C_GEN, C_MOVE, C_MOVE, C_MOVE, C_GEN};
        agum_lit_e   lk[8] = '{L_5, L_10, L_BRA, L_HOLD, L_8, L_16, L_5, L_16};
        logic [16:0] le[8] = '{17'h1F, 17'h3FF, 17'hFFFF, 17'h3FFF, 17'hFF, 17'hFFFF, 17'h10000, 17'h10000};
        for (int i = 0; i < 8; i++) begin
            rq(lc[i], M_REGDIR, U_XRD, lk[i], 4'h1, 16'h0, 16'h0, 16'hFFFF, 3'h0, 1'h0);
            chk({ansIllegal, ansMemAccess}, {le[i][16], 1'h0});
            if (!le[i][16]) begin
                chk(ansLit, le[i][15:0]);
            end
        end
        $display("literal test done");
    endtask

    task automatic t_file();
        rq(C_FILE, M_FILE, U_XRD, L_NONE, 4'h0, 16'h0, 16'h0, 16'hFFFF, 3'h0, 1'h1);
        chk({ansEa, ansDestFile, ansDestReg, ansMemAccess}, {16'h1FFF, 1'h1, DEFAULT_DEFAULT_WORKING_REGISTER, 1'h1});
        rq(C_FILE, M_FILE, U_XRD, L_NONE, 4'h0, 16'h0, 16'h0, 16'h0042, 3'h0, 1'h0);
        chk({ansDestFile, ansDestReg}, {1'h0, DEFAULT_DEFAULT_WORKING_REGISTER});
        rq(C_MOVE, M_FILE, U_XRD, L_NONE, 4'h0, 16'h0, 16'h0, 16'hFFFF, 3'h0, 1'h0);
        chk(ansEa, 16'hFFFF);
        rq(C_FILE, M_IND, U_XRD, L_NONE, 4'h1, 16'h0, 16'h0, 16'h0, 3'h0, 1'h0);
        chk(ansIllegal, 1'h1);
        $display("file test done");
    endtask

    initial begin
        #5000000;
        n_errors++;
        $display("unexpected at %0t: run limit, got %h expected %h", $time, 1'h0, 1'h1);
        end_sim();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        t_regs();
        t_xwrap();
        t_xoff();
        t_y();
        t_mac();
        t_lit();
        t_file();
        end_sim();
    end
endmodule
